// [include/bta_pkg.sv]
package bta_pkg;

	// Branch target modes presented by the decode logic with each instruction.
	typedef enum logic [2:0] {
		BTA_MODE_SEQ   = 3'h0,	// Non-branching instruction.
		BTA_MODE_REL   = 3'h1,	// Short unconditional relative branch.
		BTA_MODE_COND  = 3'h2,	// Conditional relative branch.
		BTA_MODE_LONG  = 3'h3,	// Long call or long branch, 16-bit immediate.
		BTA_MODE_FIXED = 3'h4,	// Fixed-area call, 11-bit field.
		BTA_MODE_TABLE = 3'h5,	// Vector table call.
		BTA_MODE_REG   = 3'h6	// Register branch through the accumulator pair.
	} bta_mode_e;

	typedef enum logic [1:0] {
		BTA_ST_IDLE    = 2'h0,
		BTA_ST_READ_LO = 2'h1,
		BTA_ST_READ_HI = 2'h2
	} bta_state_e;

	// One decoded instruction as handed over by the decode logic.
	typedef struct packed {
		logic             valid;
		bta_mode_e        mode;
		logic [2:0]       len;
		logic             cond_true;
		logic [7:0]       relative_displacement;
		logic [15:0]      imm16;
		logic [10:0]      short_call_field;
		logic [7:0]       opcode;
	} bta_cmd_s;

	// Read port toward program memory for vector table entries.
	typedef struct packed {
		logic             req;
		logic [15:0]      addr;
	} bta_rd_s;

	localparam logic [15:0] BTA_RESET_PC      = 16'h0000;
	localparam logic [15:0] BTA_FIXED_BASE    = 16'h0800;
	localparam logic [15:0] BTA_FIXED_TOP     = 16'h0fff;
	localparam logic [15:0] BTA_TABLE_BASE    = 16'h0040;
	localparam logic [15:0] BTA_TABLE_TOP     = 16'h007f;
	localparam int          BTA_SIGN_BIT      = 7;
	localparam int          BTA_INDEX_LSB     = 1;
	localparam int          BTA_INDEX_MSB     = 5;
	localparam int          BTA_FIELD_W       = 11;

endpackage

// [hdl/bta_unit.sv]
`timescale 1ns/100ps
// Overview of operation
// - Sequential step adds instruction byte length.
// - Relative target: following address plus displacement.
// - Displacement is signed, bit 7 sign.
// - Short branch and conditionals use relative.
// - Long forms load 16-bit immediate directly.
// - Fixed-area call lands in 0800H-0FFFH.
// - Table call reads target from 0040H-007FH.
// - Table entry chosen by opcode bits 1-5.
// - Register branch loads accumulator pair.
module bta_unit (
	input  wire logic              core_clk,   // CPU clock, 25 MHz.
	input  wire logic              rst_n,      // Synchronous reset, active low.
	input  wire bta_pkg::bta_cmd_s cmd,        // Decoded instruction from decode.
	input  wire logic [15:0]       accumulator_pair, // Accumulator pair contents.
	input  wire logic [7:0]        rd_data,    // Program memory read data.
	input  wire logic              rd_valid,   // Read data valid this cycle.
	output bta_pkg::bta_rd_s       rd_r,       // Vector table read request.
	output logic [15:0]            pc_r,       // Program counter.
	output logic                   pc_load_r,  // Pulse: pc_r took a new value.
	output logic                   busy_r      // High while a table read runs.
);

	bta_pkg::bta_state_e state_r;
	bta_pkg::bta_state_e state_nxt;
	bta_pkg::bta_rd_s    rd_nxt;
	logic [15:0]         pc_nxt;
	logic                pc_load_nxt;
	logic                busy_nxt;
	logic [7:0]          lo_byte_r;
	logic [7:0]          lo_byte_nxt;
	logic                take_w;
	logic [15:0]         follow_w;
	logic [15:0]         rel_w;

	// The decode logic must hold cmd.valid off while busy_r is high.
	assign take_w   = cmd.valid && (state_r == bta_pkg::BTA_ST_IDLE);
	assign follow_w = pc_r + {13'h0, cmd.len};
	assign rel_w    = follow_w + {{8{cmd.relative_displacement[bta_pkg::BTA_SIGN_BIT]}},
		cmd.relative_displacement};

	always_comb begin
		state_nxt   = state_r;
		rd_nxt      = rd_r;
		pc_nxt      = pc_r;
		pc_load_nxt = 1'b0;
		busy_nxt    = busy_r;
		lo_byte_nxt = lo_byte_r;
		unique case (state_r)
			bta_pkg::BTA_ST_IDLE: begin
				if (take_w) begin
					pc_load_nxt = 1'b1;
					unique case (cmd.mode)
						bta_pkg::BTA_MODE_REL: begin
							pc_nxt = rel_w;
						end
						bta_pkg::BTA_MODE_COND: begin
							pc_nxt = cmd.cond_true ? rel_w : follow_w;
						end
						bta_pkg::BTA_MODE_LONG: begin
							pc_nxt = cmd.imm16;
						end
						bta_pkg::BTA_MODE_FIXED: begin
							pc_nxt = bta_pkg::BTA_FIXED_BASE
								| {5'h00, cmd.short_call_field};
						end
						bta_pkg::BTA_MODE_TABLE: begin
							// The counter only moves once both entry bytes are in.
							pc_load_nxt = 1'b0;
							busy_nxt    = 1'b1;
							state_nxt   = bta_pkg::BTA_ST_READ_LO;
							rd_nxt.req  = 1'b1;
							rd_nxt.addr = bta_pkg::BTA_TABLE_BASE | {10'h000,
								cmd.opcode[bta_pkg::BTA_INDEX_MSB:bta_pkg::BTA_INDEX_LSB],
								1'b0};
						end
						bta_pkg::BTA_MODE_REG: begin
							pc_nxt = accumulator_pair;
						end
						bta_pkg::BTA_MODE_SEQ: begin
							pc_nxt = follow_w;
						end
						default: begin
							// Unused mode code is stepped over like a plain instruction.
							pc_nxt = follow_w;
						end
					endcase
				end
			end
			bta_pkg::BTA_ST_READ_LO: begin
				if (rd_valid) begin
					lo_byte_nxt = rd_data;
					rd_nxt.addr = rd_r.addr + 16'h0001;
					state_nxt   = bta_pkg::BTA_ST_READ_HI;
				end
			end
			bta_pkg::BTA_ST_READ_HI: begin
				if (rd_valid) begin
					pc_nxt      = {rd_data, lo_byte_r};
					pc_load_nxt = 1'b1;
					rd_nxt.req  = 1'b0;
					busy_nxt    = 1'b0;
					state_nxt   = bta_pkg::BTA_ST_IDLE;
				end
			end
			default: begin
				state_nxt  = bta_pkg::BTA_ST_IDLE;
				rd_nxt.req = 1'b0;
				busy_nxt   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r   <= bta_pkg::BTA_ST_IDLE;
			rd_r      <= '0;
			pc_r      <= bta_pkg::BTA_RESET_PC;
			pc_load_r <= 1'b0;
			busy_r    <= 1'b0;
			lo_byte_r <= 8'h00;
		end else begin
			state_r   <= state_nxt;
			rd_r      <= rd_nxt;
			pc_r      <= pc_nxt;
			pc_load_r <= pc_load_nxt;
			busy_r    <= busy_nxt;
			lo_byte_r <= lo_byte_nxt;
		end
	end

	// Helper for the relative and conditional checks: the following address, registered one cycle late.
	logic [15:0] past_follow_r;
	always_ff @(posedge core_clk) begin
		past_follow_r <= follow_w;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_SEQ_STEP: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_SEQ
		|=> pc_r == $past(pc_r) + {13'h0, $past(cmd.len)} && pc_load_r)
		else $error("Sequential step did not add the instruction length.");

	AST_REL_TARGET: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_REL
		|=> pc_r == past_follow_r + {{8{$past(cmd.relative_displacement[7])}},
			$past(cmd.relative_displacement)})
		else $error("Relative target is not following address plus displacement.");

	AST_REL_SIGN: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_REL
		|=> (16'(pc_r - past_follow_r) >> 7) ==
			($past(cmd.relative_displacement[7]) ? 16'h01ff : 16'h0000))
		else $error("Relative displacement was not sign extended from bit 7.");

	AST_COND_PATH: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_COND
		|=> pc_r == ($past(cmd.cond_true)
			? past_follow_r + {{8{$past(cmd.relative_displacement[7])}},
				$past(cmd.relative_displacement)}
			: past_follow_r))
		else $error("Conditional branch target is wrong.");

	AST_LONG_LOAD: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_LONG |=> pc_r == $past(cmd.imm16) && pc_load_r)
		else $error("Long form did not load the immediate address.");

	AST_FIXED_AREA: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_FIXED
		|=> pc_r >= bta_pkg::BTA_FIXED_BASE && pc_r <= bta_pkg::BTA_FIXED_TOP)
		else $error("Fixed-area call left its area.");

	AST_FIXED_FIELD: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_FIXED
		|=> pc_r[10:0] == $past(cmd.short_call_field))
		else $error("Fixed-area call low bits differ from the field.");

	AST_TABLE_RANGE: assert property (
		rd_r.req
		|-> rd_r.addr >= bta_pkg::BTA_TABLE_BASE && rd_r.addr <= bta_pkg::BTA_TABLE_TOP)
		else $error("Vector read outside the table.");

	AST_TABLE_INDEX: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_TABLE
		|=> rd_r.req && busy_r && !pc_load_r
			&& rd_r.addr == bta_pkg::BTA_TABLE_BASE + {10'h000, $past(cmd.opcode[5:1]), 1'b0})
		else $error("Vector entry address does not follow opcode bits 1 to 5.");

	AST_TABLE_LOAD: assert property (
		state_r == bta_pkg::BTA_ST_READ_HI && rd_valid
		|=> pc_r == {$past(rd_data), $past(lo_byte_r)} && pc_load_r && !busy_r && !rd_r.req)
		else $error("Vector entry was not loaded into the counter.");

	AST_REG_LOAD: assert property (
		take_w && cmd.mode == bta_pkg::BTA_MODE_REG |=> pc_r == $past(accumulator_pair))
		else $error("Register branch did not load the accumulator pair.");

	AST_IDLE_LOAD: assert property (
		take_w && cmd.mode != bta_pkg::BTA_MODE_TABLE
		|=> pc_load_r && !busy_r)
		else $error("Counter was not loaded one cycle after the instruction.");

	// The read port keeps its request and address standing until each byte arrives,
	// so a slow program memory never sees the address move under it.
	AST_BUSY_REQ: assert property (
		busy_r == rd_r.req)
		else $error("Busy flag and read request disagree.");

	AST_BUSY_NO_LOAD: assert property (
		busy_r |-> !pc_load_r)
		else $error("Counter loaded while a vector read was still running.");

	AST_TABLE_NEXT: assert property (
		state_r == bta_pkg::BTA_ST_READ_LO && rd_valid
		|=> state_r == bta_pkg::BTA_ST_READ_HI && rd_r.addr == $past(rd_r.addr) + 16'h0001)
		else $error("High entry byte is not read from the next address.");

	AST_TABLE_WAIT: assert property (
		state_r != bta_pkg::BTA_ST_IDLE && !rd_valid
		|=> busy_r && rd_r.req && $stable(rd_r.addr) && $stable(pc_r))
		else $error("Vector read did not hold while waiting for data.");

endmodule // bta_unit

// [verification/bta_mem_model.sv]
`timescale 1ns/100ps
module bta_mem_model (
	input  wire logic             core_clk, // CPU clock.
	input  wire logic             rst_n,    // Synchronous reset, active low.
	input  wire bta_pkg::bta_rd_s rd,       // Read request from the unit.
	input  wire logic [1:0]       slow,     // Wait cycles before each byte.
	output logic [7:0]            rd_data,  // Byte returned.
	output logic                  rd_valid  // Byte valid this cycle.
);
	logic [1:0] wait_r;

	// Idle data is inverted each cycle so a late sample never passes by luck.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			wait_r   <= 2'h0;
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end else if (rd.req && !rd_valid && wait_r >= slow) begin
			wait_r   <= 2'h0;
			rd_valid <= 1'b1;
			rd_data  <= rd.addr[7:0] * 8'h1d + 8'h3c;
		end else begin
			if (rd.req && !rd_valid)
				wait_r <= wait_r + 2'h1;
			rd_valid <= 1'b0;
			rd_data  <= ~rd_data;
		end
	end
endmodule // bta_mem_model

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
	logic              core_clk;
	logic              rst_n;
	bta_pkg::bta_cmd_s cmd;
	bta_pkg::bta_rd_s  rd_r;
	logic [15:0]       acc;
	logic [15:0]       pc_r;
	logic [15:0]       exp_pc;
	logic [7:0]        rd_data;
	logic              rd_valid;
	logic              pc_load_r;
	logic              busy_r;
	logic [1:0]        slow;
	logic [31:0]       seed;
	int                bad_count;
	int                tests_run;
	int                i;
	logic              hung;

	bta_unit uut (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .accumulator_pair(acc),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_r(rd_r), .pc_r(pc_r),
		.pc_load_r(pc_load_r), .busy_r(busy_r));
	bta_mem_model mem (.core_clk(core_clk), .rst_n(rst_n), .rd(rd_r), .slow(slow),
		.rd_data(rd_data), .rd_valid(rd_valid));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic step(input logic [2:0] m);
		logic [15:0] a;
		int          n;
		@(negedge core_clk);
		cmd.valid = 1'b1;
		cmd.mode = bta_pkg::bta_mode_e'(m);
		cmd.len = 3'(1 + xs() % 4);
		{cmd.cond_true, cmd.relative_displacement, cmd.imm16} = 25'(xs());
		{cmd.short_call_field, cmd.opcode} = 19'(xs());
		acc = 16'(xs());
		slow = 2'(xs());
		a = 16'h0040 + {10'h0, cmd.opcode[5:1], 1'b0};
		exp_pc = exp_pc + 16'(cmd.len);
		if (m == 3'h1 || (m == 3'h2 && cmd.cond_true))
			exp_pc = exp_pc + {{8{cmd.relative_displacement[7]}}, cmd.relative_displacement};
		if (m == 3'h3)
			exp_pc = cmd.imm16;
		if (m == 3'h4)
			exp_pc = 16'h0800 | 16'(cmd.short_call_field);
		if (m == 3'h5)
			exp_pc = {(a[7:0] + 8'h01) * 8'h1d + 8'h3c, a[7:0] * 8'h1d + 8'h3c};
		if (m == 3'h6)
			exp_pc = acc;
		@(posedge core_clk);
		#1;
		if (m == 3'h5) begin
			chk("table address", a, rd_r.addr);
			chk("busy", 16'h1, 16'(busy_r));
			chk("table req", 16'h1, 16'(rd_r.req));
			@(negedge core_clk);
			cmd.valid = 1'b0;
			n = 0;
			while (pc_load_r !== 1'b1 && n < 50) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			if (pc_load_r !== 1'b1)
				hung = 1'b1;
		end
		chk("load pulse", 16'h1, 16'(pc_load_r));
		chk("busy after load", 16'h0, 16'(busy_r));
		chk("pc", exp_pc, pc_r);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		seed = 32'd72450;
		rst_n = 1'b0;
		cmd = '0;
		acc = 16'h0000;
		slow = 2'h0;
		exp_pc = 16'h0000;
		bad_count = 0;
		tests_run = 0;
		hung = 1'b0;
		repeat (16) @(negedge core_clk);
		rst_n = 1'b1;
		chk("reset pc", 16'h0000, pc_r);
		for (i = 0; i < 400 && !hung; i++)
			step(3'(xs()));
		$display("random branch sequence done");
		@(negedge core_clk);
		cmd.valid = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("pc after reset", 16'h0000, pc_r);
		chk("busy after reset", 16'h0000, 16'(busy_r));
		chk("req after reset", 16'h0000, 16'(rd_r.req));
		rst_n = 1'b1;
		exp_pc = 16'h0000;
		for (i = 0; i < 40 && !hung; i++)
			step(3'(xs()));
		$display("restart after reset done");
		close_out();
	end
endmodule // tb
